/* sdh_map.svh */
`ifndef SDH_MAP_SVH
`define SDH_MAP_SVH
// ----------------------------------------
// Command indices
// ----------------------------------------
`define SDH_CMD_SET_DSR   6'h04
`define SDH_CMD_STOP      6'h0C
`define SDH_CMD_STATUS    6'h0D
`define SDH_CMD_WR_COUNT  6'h16
`define SDH_CMD_GEN       6'h38
// ----------------------------------------
// Timing
// ----------------------------------------
`define SDH_CLK_HZ        50000000
`define SDH_RSP_TO_CYC    64
`define SDH_RD_TO_MS      100
`define SDH_WR_TO_MS      1000
`define SDH_RD_TO_CLK     ((`SDH_CLK_HZ / 1000) * `SDH_RD_TO_MS)
`define SDH_WR_TO_CLK     ((`SDH_CLK_HZ / 1000) * `SDH_WR_TO_MS)
`define SDH_TMR_W         26
`endif

/* sdh_pkg.sv */
package sdh_pkg;
  typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_WRSP, S_WDAT} sdh_state_t;
  typedef enum logic [2:0] {P_MAIN, P_STOP, P_STAT, P_APP, P_CNT} sdh_phase_t;
  typedef enum logic [2:0] {E_NONE, E_RETRY, E_RECOV, E_PROTO, E_EXEC} sdh_err_t;
  typedef enum logic [2:0] {
    X_NONE, X_RETRY_EXH, X_PROTO, X_EXEC, X_UNSUP, X_PARTIAL
  } sdh_exc_t;
endpackage : sdh_pkg

/* sdh_tmr_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sdh_tmr_if #(parameter int W = 26);
  logic         run;
  logic         clr;
  logic         tick;
  logic [W-1:0] limit;
  logic         expired;
  modport ctl (output run, clr, tick, limit, input expired);
  modport tmr (input run, clr, tick, limit, output expired);
endinterface : sdh_tmr_if
`default_nettype wire

/* sdh_tmr.sv */
`timescale 1ns/1ps
`default_nettype none
module sdh_tmr #(
  parameter int W = 26
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Control
  sdh_tmr_if.tmr    t
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // Saturates at the limit so a late answer cannot wrap into a fresh window
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (t.clr || !t.run)
      cnt_nxt = '0;
    else if (t.tick && cnt_r != t.limit)
      cnt_nxt = cnt_r + {{(W-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  // Not gated by clr: clr follows the state change that expiry itself causes
  assign t.expired = t.run && (cnt_r == t.limit);
endmodule // sdh_tmr
`default_nettype wire

/* sdh_err_seq.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sdh_map.svh"
module sdh_err_seq
  import sdh_pkg::*;
#(
  parameter int          RETRY_LIMIT = 3,
  parameter logic [5:0]  APP_CMD     = 6'h37,
  parameter int          RD_TO_CLK   = `SDH_RD_TO_CLK,
  parameter int          WR_TO_CLK   = `SDH_WR_TO_CLK
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // User request
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [5:0]  req_idx,
  input  wire logic [31:0] req_arg,
  input  wire logic        req_data,
  input  wire logic        req_multi,
  input  wire logic        req_write,
  input  wire logic [31:0] req_blocks,
  // User result
  output logic             done,
  output logic             exc_valid,
  output sdh_exc_t         exc_code,
  output logic [31:0]      wr_count,
  // Command engine
  output logic             cmd_valid,
  input  wire logic        cmd_ready,
  output logic [5:0]       cmd_idx,
  output logic [31:0]      cmd_arg,
  input  wire logic        sd_tick,
  // Response classification
  input  wire logic        rsp_valid,
  input  wire logic        rsp_crc_bad,
  input  wire logic        rsp_gen_err,
  input  wire logic        rsp_proto_err,
  input  wire logic        rsp_exec_err,
  // Data engine
  input  wire logic        dat_done,
  input  wire logic        dat_err,
  input  wire logic [31:0] dat_word
);
  localparam int CW = $clog2(RETRY_LIMIT + 1);
  localparam logic [CW-1:0] LIM = CW'(RETRY_LIMIT);
  localparam logic [CW-1:0] ONE = CW'(1);

  // Limits beyond the timer width would wrap to a shorter value and expire too early
  if (RETRY_LIMIT < 1 || RD_TO_CLK < 1 || WR_TO_CLK < 1 ||
      RD_TO_CLK >= 2**`SDH_TMR_W || WR_TO_CLK >= 2**`SDH_TMR_W)
  begin : g_bad_param
    $error("sdh_err_seq: unsupported parameter value");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  sdh_state_t       st_r, st_nxt;
  sdh_phase_t       ph_r, ph_nxt;
  sdh_err_t         err_r, err_nxt;
  sdh_exc_t         code_r, code_nxt;
  logic [5:0]       idx_r, idx_nxt, m_idx_r, m_idx_nxt;
  logic [31:0]      arg_r, arg_nxt, m_arg_r, m_arg_nxt;
  logic [31:0]      blk_r, blk_nxt, cnt_r, cnt_nxt;
  logic             data_r, data_nxt, multi_r, multi_nxt, wr_r, wr_nxt;
  logic             dfail_r, dfail_nxt, done_r, done_nxt, exc_r, exc_nxt;
  logic [CW-1:0]    retry_r, retry_nxt;

  sdh_tmr_if #(.W(`SDH_TMR_W)) tif ();

  sdh_tmr #(.W(`SDH_TMR_W)) sdh_tmr_inst (
    .clk  (clk),
    .nrst (nrst),
    .t    (tif.tmr)
  );

  // Card command 4 and 56 are absent on this card
  function automatic logic unsup(input logic [5:0] i);
    return (i == `SDH_CMD_SET_DSR) || (i == `SDH_CMD_GEN);
  endfunction

  // ----------------------------------------
  // Timer control
  // ----------------------------------------
  assign tif.run   = (st_r == S_WRSP) || (st_r == S_WDAT);
  assign tif.clr   = (st_r != st_nxt);
  assign tif.tick  = (st_r == S_WRSP) ? sd_tick : 1'b1;
  assign tif.limit = (st_r == S_WRSP) ? `SDH_TMR_W'(`SDH_RSP_TO_CYC) :
                     wr_r ? `SDH_TMR_W'(WR_TO_CLK) : `SDH_TMR_W'(RD_TO_CLK);

  assign req_ready = (st_r == S_IDLE);
  assign cmd_valid = (st_r == S_ISSUE);
  assign cmd_idx   = idx_r;
  assign cmd_arg   = arg_r;
  assign done      = done_r;
  assign exc_valid = exc_r;
  assign exc_code  = code_r;
  assign wr_count  = cnt_r;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb
  begin : seq
    logic go_exc;
    logic go_issue;
    logic go_done;
    sdh_exc_t xc;
    go_exc = 1'b0;
    go_issue = 1'b0;
    go_done = 1'b0;
    xc = X_NONE;
    st_nxt = st_r;
    ph_nxt = ph_r;
    err_nxt = err_r;
    code_nxt = code_r;
    idx_nxt = idx_r;
    arg_nxt = arg_r;
    m_idx_nxt = m_idx_r;
    m_arg_nxt = m_arg_r;
    blk_nxt = blk_r;
    cnt_nxt = cnt_r;
    data_nxt = data_r;
    multi_nxt = multi_r;
    wr_nxt = wr_r;
    dfail_nxt = dfail_r;
    retry_nxt = retry_r;
    done_nxt = 1'b0;
    exc_nxt = 1'b0;
    case (st_r)
      S_IDLE:
      begin
        if (req_valid && unsup(req_idx))
        begin
          go_exc = 1'b1;
          xc = X_UNSUP;
        end
        else if (req_valid)
        begin
          m_idx_nxt = req_idx;
          m_arg_nxt = req_arg;
          data_nxt = req_data;
          multi_nxt = req_multi;
          wr_nxt = req_write;
          blk_nxt = req_blocks;
          err_nxt = E_NONE;
          dfail_nxt = 1'b0;
          ph_nxt = P_MAIN;
          idx_nxt = req_idx;
          arg_nxt = req_arg;
          st_nxt = S_ISSUE;
        end
      end
      S_ISSUE:
        if (cmd_ready)
          st_nxt = S_WRSP;
      S_WRSP:
      begin
        if (ph_r == P_MAIN && (rsp_valid || tif.expired))
        begin
          if (!rsp_valid || rsp_crc_bad)
            err_nxt = E_RETRY;
          else if (rsp_proto_err)
            err_nxt = E_PROTO;
          else if (rsp_gen_err)
            err_nxt = E_RECOV;
          else if (rsp_exec_err)
            err_nxt = E_EXEC;
          if ((!rsp_valid || rsp_crc_bad || rsp_proto_err || rsp_gen_err || rsp_exec_err))
          begin
            ph_nxt = P_STAT;
            idx_nxt = `SDH_CMD_STATUS;
            arg_nxt = '0;
            st_nxt = S_ISSUE;
          end
          else if (data_r)
            st_nxt = S_WDAT;
          else
            go_done = 1'b1;
        end
        else if (rsp_valid || tif.expired)
        begin
          // Follow-up answers are not judged; a stale error was cleared by status
          case (ph_r)
            P_STOP:
              if (err_r == E_NONE && !dfail_r)
                go_done = 1'b1;
              else
              begin
                ph_nxt = P_STAT;
                idx_nxt = `SDH_CMD_STATUS;
                arg_nxt = '0;
                st_nxt = S_ISSUE;
              end
            P_STAT:
              if (dfail_r && multi_r && wr_r)
              begin
                ph_nxt = P_APP;
                idx_nxt = APP_CMD;
                arg_nxt = '0;
                st_nxt = S_ISSUE;
              end
              else if (err_r == E_PROTO)
              begin
                go_exc = 1'b1;
                xc = X_PROTO;
              end
              else if (err_r == E_EXEC)
              begin
                go_exc = 1'b1;
                xc = X_EXEC;
              end
              else if (retry_r == LIM)
              begin
                go_exc = 1'b1;
                xc = X_RETRY_EXH;
              end
              else
                go_issue = 1'b1;
            P_APP:
            begin
              ph_nxt = P_CNT;
              idx_nxt = `SDH_CMD_WR_COUNT;
              arg_nxt = '0;
              st_nxt = S_ISSUE;
            end
            default:
              st_nxt = rsp_valid ? S_WDAT : S_IDLE;
          endcase
          if (ph_r == P_CNT && !rsp_valid)
          begin
            go_exc = 1'b1;
            xc = X_PARTIAL;
          end
        end
      end
      S_WDAT:
      begin
        if (ph_r == P_CNT && (dat_done || tif.expired))
        begin
          cnt_nxt = dat_done ? dat_word : '0;
          if (!dat_done || dat_err || dat_word < blk_r)
          begin
            go_exc = 1'b1;
            xc = X_PARTIAL;
          end
          else
            go_done = 1'b1;
        end
        else if (dat_done || tif.expired)
        begin
          dfail_nxt = !dat_done || dat_err;
          if (!dat_done || dat_err)
            err_nxt = E_RECOV;
          arg_nxt = '0;
          st_nxt = S_ISSUE;
          if (multi_r)
          begin
            ph_nxt = P_STOP;
            idx_nxt = `SDH_CMD_STOP;
          end
          else if (!dat_done || dat_err)
          begin
            ph_nxt = P_STAT;
            idx_nxt = `SDH_CMD_STATUS;
          end
          else
          begin
            st_nxt = S_IDLE;
            go_done = 1'b1;
          end
        end
      end
      default:
        st_nxt = S_IDLE;
    endcase
    if (go_issue)
    begin
      retry_nxt = retry_r + ONE;
      ph_nxt = P_MAIN;
      idx_nxt = m_idx_r;
      arg_nxt = m_arg_r;
      err_nxt = E_NONE;
      dfail_nxt = 1'b0;
      st_nxt = S_ISSUE;
    end
    if (go_done || go_exc)
    begin
      retry_nxt = '0;
      st_nxt = S_IDLE;
      done_nxt = go_done;
      exc_nxt = go_exc;
      code_nxt = go_exc ? xc : X_NONE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_r <= S_IDLE;
      ph_r <= P_MAIN;
      err_r <= E_NONE;
      code_r <= X_NONE;
      idx_r <= '0;
      arg_r <= '0;
      m_idx_r <= '0;
      m_arg_r <= '0;
      blk_r <= '0;
      cnt_r <= '0;
      data_r <= 1'b0;
      multi_r <= 1'b0;
      wr_r <= 1'b0;
      dfail_r <= 1'b0;
      retry_r <= '0;
      done_r <= 1'b0;
      exc_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      ph_r <= ph_nxt;
      err_r <= err_nxt;
      code_r <= code_nxt;
      idx_r <= idx_nxt;
      arg_r <= arg_nxt;
      m_idx_r <= m_idx_nxt;
      m_arg_r <= m_arg_nxt;
      blk_r <= blk_nxt;
      cnt_r <= cnt_nxt;
      data_r <= data_nxt;
      multi_r <= multi_nxt;
      wr_r <= wr_nxt;
      dfail_r <= dfail_nxt;
      retry_r <= retry_nxt;
      done_r <= done_nxt;
      exc_r <= exc_nxt;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_unsup_rej;
    @(posedge clk) disable iff (!nrst)
    req_ready && req_valid && unsup(req_idx) |=> exc_valid && exc_code == X_UNSUP && !cmd_valid;
  endproperty
  a_unsup_rej: assert property (p_unsup_rej) else $error("unsupported command not refused");

  property p_never_unsup;
    @(posedge clk) disable iff (!nrst) cmd_valid |-> !unsup(cmd_idx);
  endproperty
  a_never_unsup: assert property (p_never_unsup) else $error("unsupported command issued");

  property p_rsp_to;
    @(posedge clk) disable iff (!nrst)
    st_r == S_WRSP && ph_r == P_MAIN && !rsp_valid && tif.expired
    |=> cmd_valid && cmd_idx == `SDH_CMD_STATUS && err_r == E_RETRY;
  endproperty
  a_rsp_to: assert property (p_rsp_to) else $error("response timeout not handled");

  property p_proto;
    @(posedge clk) disable iff (!nrst)
    st_r == S_WRSP && ph_r == P_MAIN && rsp_valid && !rsp_crc_bad && rsp_proto_err
    |=> err_r == E_PROTO && cmd_idx == `SDH_CMD_STATUS;
  endproperty
  a_proto: assert property (p_proto) else $error("protocol error not classed");

  property p_gen;
    @(posedge clk) disable iff (!nrst)
    st_r == S_WRSP && ph_r == P_MAIN && rsp_valid && !rsp_crc_bad && !rsp_proto_err && rsp_gen_err
    |=> err_r == E_RECOV;
  endproperty
  a_gen: assert property (p_gen) else $error("general error not recovered");

  property p_limit;
    @(posedge clk) disable iff (!nrst)
    exc_valid && exc_code == X_RETRY_EXH |-> $past(retry_r) == LIM;
  endproperty
  a_limit: assert property (p_limit) else $error("retry exhaustion at wrong count");

  property p_clr;
    @(posedge clk) disable iff (!nrst) done || exc_valid |-> retry_r == '0;
  endproperty
  a_clr: assert property (p_clr) else $error("retry count not cleared");

  property p_stop;
    @(posedge clk) disable iff (!nrst)
    st_r == S_WDAT && ph_r == P_MAIN && multi_r && (tif.expired || (dat_done && dat_err))
    |=> cmd_valid && cmd_idx == `SDH_CMD_STOP ##1 dfail_r;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not sent after data failure");

  property p_busy;
    @(posedge clk) disable iff (!nrst)
    st_r == S_WRSP && ph_r == P_MAIN &&
    ((!rsp_valid && tif.expired) ||
     (rsp_valid && (rsp_crc_bad || rsp_proto_err || rsp_gen_err || rsp_exec_err)))
    |=> cmd_valid && cmd_idx == `SDH_CMD_STATUS && !req_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("request taken during error handling");

  c_retry: cover property (@(posedge clk) disable iff (!nrst)
    err_r == E_RETRY ##[1:200] cmd_valid && ph_r == P_MAIN);
  c_exh: cover property (@(posedge clk) disable iff (!nrst) exc_valid && exc_code == X_RETRY_EXH);
  c_cnt: cover property (@(posedge clk) disable iff (!nrst) ph_r == P_CNT && dat_done);
endmodule // sdh_err_seq
`default_nettype wire

/* sdh_card_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Card stand-in behind the command and data engines
// ----------------------------------------
// No drive-strength or internal write-protect control is modelled at all
module sdh_card_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Scenario control
  input  wire logic        arm,
  input  wire logic [5:0]  main_idx,
  input  wire logic [2:0]  kind,
  input  wire logic [3:0]  nfail,
  input  wire logic        dat_on,
  input  wire logic [31:0] cnt,
  input  wire logic [4:0]  dly,
  output logic [7:0]       bad_cmd,
  // Command side
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [5:0]  cmd_idx,
  output logic             sd_tick,
  // Response side
  output logic             rsp_valid,
  output logic             rsp_crc_bad,
  output logic             rsp_proto_err,
  output logic             rsp_gen_err,
  output logic             rsp_exec_err,
  // Data side
  output logic             dat_done,
  output logic             dat_err,
  output logic [31:0]      dat_word
);
  logic [1:0]  ph;
  logic [4:0]  w;
  logic [5:0]  idx;
  logic        fail;
  logic [3:0]  issues;
  logic [3:0]  q;
  logic        derr;
  logic [31:0] word;
  logic        junk;

  // Qualifiers mean nothing without their strobe, so they wander in between
  assign {rsp_crc_bad, rsp_proto_err, rsp_gen_err, rsp_exec_err} = rsp_valid ? q : {4{junk}};
  assign dat_err  = dat_done ? derr : junk;
  assign dat_word = dat_done ? word : ~word;

  always @(posedge clk)
  begin
    junk      <= ~junk;
    sd_tick   <= ~sd_tick;
    cmd_ready <= 1'b0;
    rsp_valid <= 1'b0;
    dat_done  <= 1'b0;
    if (arm)
      issues <= 4'h0;
    if (!nrst)
    begin
      ph      <= 2'h0;
      junk    <= 1'b0;
      sd_tick <= 1'b0;
      bad_cmd <= 8'h00;
      issues  <= 4'h0;
      q       <= 4'h0;
      derr    <= 1'b0;
      word    <= 32'h0;
    end
    else
      case (ph)
        2'h0: if (cmd_valid)
        begin
          w  <= dly;
          ph <= 2'h1;
        end
        2'h1: if (w != 5'h0)
          w <= w - 5'h1;
        else
        begin
          cmd_ready <= 1'b1;
          idx       <= cmd_idx;
          w         <= dly;
          ph        <= 2'h2;
          fail      <= (cmd_idx == main_idx) && (issues < nfail);
          if (cmd_idx == main_idx)
            issues <= issues + 4'h1;
          // Unsupported register-program and vendor commands are counted as faults
          if (cmd_idx == 6'h04 || cmd_idx == 6'h38)
            bad_cmd <= bad_cmd + 8'h01;
        end
        2'h2: if (w != 5'h0)
          w <= w - 5'h1;
        else if (fail && kind == 3'h1)
          ph <= 2'h0;
        else
        begin
          rsp_valid <= 1'b1;
          q  <= fail ? {kind == 3'h2, kind == 3'h4, kind == 3'h3, kind == 3'h5} : 4'h0;
          w  <= dly;
          ph <= (((idx == main_idx) && dat_on) || idx == 6'h16) && !(fail && kind < 3'h6)
                ? 2'h3 : 2'h0;
        end
        default: if (w != 5'h0)
          w <= w - 5'h1;
        else
        begin
          ph <= 2'h0;
          if (!(fail && kind == 3'h6))
          begin
            dat_done <= 1'b1;
            derr     <= fail && kind == 3'h7;
            word     <= cnt;
          end
        end
      endcase
  end
endmodule // sdh_card_model
`default_nettype wire

/* sdh_err_seq_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sdh_err_seq_tb
  import sdh_pkg::*;
;
  localparam int RD_TO   = 200;
  localparam int WR_TO   = 300;
  localparam int MAX_CYC = 20000;
  typedef struct {
    logic [5:0]  idx;
    logic [2:0]  mode;
    logic [2:0]  kind;
    logic [3:0]  nfail;
    logic [31:0] cnt;
    sdh_exc_t    exc;
    logic [3:0]  n;
    logic [5:0]  last;
  } sdh_row_t;

  logic clk, nrst, req_valid, req_ready, req_data, req_multi, req_write, done, exc_valid;
  logic [5:0]  req_idx, cmd_idx, main_idx, last_idx;
  logic [31:0] req_arg, req_blocks, wr_count, cnt, dat_word, cmd_arg;
  sdh_exc_t    exc_code;
  logic        cmd_valid, cmd_ready, sd_tick, rsp_valid, rsp_crc_bad, rsp_gen_err;
  logic        rsp_proto_err, rsp_exec_err, dat_done, dat_err, arm, dat_on;
  logic [2:0]  kind;
  logic [3:0]  nfail;
  logic [4:0]  dly;
  logic [7:0]  bad_cmd;
  int          n_mismatch, n_compared, n_cmd, cyc, t_acc, gap1;

  // Mode bits: data phase, multi-block, write
  sdh_row_t rows [15] = '{
    '{6'h11, 3'b000, 3'h0, 4'h0, 32'h0, X_NONE, 4'h1, 6'h11},
    '{6'h11, 3'b000, 3'h1, 4'h1, 32'h0, X_NONE, 4'h3, 6'h11},
    '{6'h11, 3'b000, 3'h2, 4'h7, 32'h0, X_RETRY_EXH, 4'h6, 6'h0D},
    '{6'h11, 3'b000, 3'h2, 4'h2, 32'h0, X_NONE, 4'h5, 6'h11},
    '{6'h11, 3'b000, 3'h3, 4'h1, 32'h0, X_NONE, 4'h3, 6'h11},
    '{6'h11, 3'b000, 3'h4, 4'h1, 32'h0, X_PROTO, 4'h2, 6'h0D},
    '{6'h11, 3'b000, 3'h5, 4'h1, 32'h0, X_EXEC, 4'h2, 6'h0D},
    '{6'h04, 3'b000, 3'h0, 4'h0, 32'h0, X_UNSUP, 4'h0, 6'h00},
    '{6'h38, 3'b000, 3'h0, 4'h0, 32'h0, X_UNSUP, 4'h0, 6'h00},
    '{6'h12, 3'b110, 3'h0, 4'h0, 32'h0, X_NONE, 4'h2, 6'h0C},
    '{6'h12, 3'b110, 3'h6, 4'h1, 32'h0, X_NONE, 4'h5, 6'h0C},
    '{6'h11, 3'b100, 3'h7, 4'h1, 32'h0, X_NONE, 4'h3, 6'h11},
    '{6'h19, 3'b111, 3'h7, 4'h1, 32'h4, X_NONE, 4'h5, 6'h16},
    '{6'h19, 3'b111, 3'h7, 4'h1, 32'h2, X_PARTIAL, 4'h5, 6'h16},
    '{6'h19, 3'b111, 3'h6, 4'h1, 32'h4, X_NONE, 4'h5, 6'h16}
  };

  sdh_err_seq #(.RETRY_LIMIT(2), .RD_TO_CLK(RD_TO), .WR_TO_CLK(WR_TO)) sdh_err_seq_inst (
    .clk(clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready), .req_idx(req_idx),
    .req_arg(req_arg), .req_data(req_data), .req_multi(req_multi), .req_write(req_write),
    .req_blocks(req_blocks), .done(done), .exc_valid(exc_valid), .exc_code(exc_code),
    .wr_count(wr_count), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_idx(cmd_idx),
    .cmd_arg(cmd_arg), .sd_tick(sd_tick), .rsp_valid(rsp_valid), .rsp_crc_bad(rsp_crc_bad),
    .rsp_gen_err(rsp_gen_err), .rsp_proto_err(rsp_proto_err), .rsp_exec_err(rsp_exec_err),
    .dat_done(dat_done), .dat_err(dat_err), .dat_word(dat_word));

  sdh_card_model sdh_card_model_inst (
    .clk(clk), .nrst(nrst), .arm(arm), .main_idx(main_idx), .kind(kind), .nfail(nfail),
    .dat_on(dat_on), .cnt(cnt), .dly(dly), .bad_cmd(bad_cmd), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_idx(cmd_idx), .sd_tick(sd_tick), .rsp_valid(rsp_valid),
    .rsp_crc_bad(rsp_crc_bad), .rsp_proto_err(rsp_proto_err), .rsp_gen_err(rsp_gen_err),
    .rsp_exec_err(rsp_exec_err), .dat_done(dat_done), .dat_err(dat_err), .dat_word(dat_word));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Monitor sees pre-edge values, so a handshake is counted exactly once
  always @(posedge clk)
  begin
    cyc++;
    if (nrst === 1'b1 && cmd_valid === 1'b1 && cmd_ready === 1'b1)
    begin
      if (n_cmd == 1)
        gap1 = cyc - t_acc;
      t_acc = cyc;
      n_cmd++;
      last_idx = cmd_idx;
      check(cmd_arg, (cmd_idx == main_idx) ? {26'h0, main_idx} : 32'h0);
    end
    if (cyc == MAX_CYC)
    begin
      n_mismatch++;
      $display("[FAIL] %0t run did not finish", $time);
      stop_test();
    end
  end

  task automatic start(input sdh_row_t r, input logic [4:0] d);
    @(negedge clk);
    {req_data, req_multi, req_write} = r.mode;
    req_idx = r.idx;
    req_arg = {26'h0, r.idx};
    main_idx = r.idx;
    kind = r.kind;
    nfail = r.nfail;
    cnt = r.cnt;
    dat_on = r.mode[2];
    dly = d;
    arm = 1'b1;
    req_valid = 1'b1;
    n_cmd = 0;
    while (req_ready !== 1'b1)
      @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    arm = 1'b0;
  endtask

  task automatic run(input sdh_row_t r, input logic [4:0] d);
    int k;
    int lo;
    start(r, d);
    k = 0;
    while (done !== 1'b1 && exc_valid !== 1'b1 && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    check(done | exc_valid, 1'b1);
    check(done ? X_NONE : exc_code, r.exc);
    check(n_cmd, r.n);
    if (r.n != 4'h0)
      check(last_idx, r.last);
    if (r.last == 6'h16)
      check(wr_count, r.cnt);
    if (r.nfail != 4'h0 && (r.kind == 3'h1 || r.kind == 3'h6))
    begin
      lo = (r.kind == 3'h1) ? 126 : (r.mode[0] ? WR_TO : RD_TO);
      check(gap1 >= lo && gap1 <= lo + 2 * d + 12, 1'b1);
    end
    $display("test idx %h kind %0d ended after %0d commands", r.idx, r.kind, n_cmd);
  endtask

  task automatic chk_rst();
    check(req_ready, 1'b1);
    check(cmd_valid, 1'b0);
    check(done | exc_valid, 1'b0);
    check(exc_code, X_NONE);
    check(wr_count, 32'h0);
  endtask

  initial
  begin
    {nrst, req_valid, req_data, req_multi, req_write, arm, dat_on} = '0;
    {req_idx, main_idx, kind, nfail, dly} = '0;
    {req_arg, cnt} = '0;
    req_blocks = 32'h4;
    repeat (2) @(negedge clk);
    chk_rst();
    $display("test reset at start ended");
    nrst = 1'b1;
    foreach (rows[i])
      run(rows[i], (i % 2) ? 5'd12 : 5'd1);
    // Reset in the middle of a retry loop must leave no command or stale code behind
    start(rows[2], 5'd1);
    repeat (12) @(negedge clk);
    nrst = 1'b0;
    @(negedge clk);
    chk_rst();
    $display("test reset in retry loop ended");
    nrst = 1'b1;
    run(rows[3], 5'd1);
    check(bad_cmd, 8'h00);
    stop_test();
  end
endmodule // sdh_err_seq_tb
`default_nettype wire
